// [hw/ssw_pkg.sv]
// Package: shared constants for the serial switch control port and its host.
// Assumes both ends run on clk_sys_i at 25 MHz.
package ssw_pkg;
  localparam int          SSW_FRAME_BITS  = 24;
  localparam int          SSW_NUM_OUT     = 16;
  localparam int          SSW_CNT_W       = 5;
  localparam int          SSW_CMD_HI      = 23;
  localparam int          SSW_CMD_LO      = 18;
  localparam int          SSW_ANY_BIT     = 23;
  localparam int          SSW_OV_BIT      = 22;
  localparam int          SSW_CMD_W       = 6;
  localparam logic [5:0]  SSW_CMD_ONOFF   = 6'h00;
  localparam logic [15:0] SSW_OUT_RST     = 16'h0000;
  localparam logic [4:0]  SSW_CNT_FULL    = 5'h18;
  // Clock and fault filter timing
  localparam int          SSW_CLK_MHZ     = 25;
  localparam int          SSW_FLT_MIN_US  = 100;
  localparam int          SSW_FLT_MAX_US  = 450;
  // Filter at the midpoint of the allowed window, well inside both bounds
  localparam int          SSW_FLT_CYC     = (SSW_FLT_MIN_US + SSW_FLT_MAX_US) / 2 * SSW_CLK_MHZ;
  localparam int          SSW_FLT_W       = 14;
  // Host link clock: 6.0 MHz ceiling; the rounded-up half period plus one is 4 sys cycles (3.125 MHz)
  localparam int          SSW_SCK_MAX_KHZ = 6000;
  localparam int          SSW_HALF_CYC    = (SSW_CLK_MHZ * 1000 + 2 * SSW_SCK_MAX_KHZ - 1)
                                            / (2 * SSW_SCK_MAX_KHZ) + 1;
  localparam int          SSW_DIV_W       = 3;
  // Gap between accesses must exceed 450 us
  localparam int          SSW_GAP_CYC     = SSW_FLT_MAX_US * SSW_CLK_MHZ + 1;
  localparam int          SSW_GAP_W       = 14;
endpackage

// [hw/ssw_if.sv]
// Interface: serial link between host and switch port.
// Assumes the bench resolves the data-out wire from its enable.
`timescale 1ns/10ps
interface ssw_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  // No pull on the data-out wire, so a released pin shows the inverse of the last bit
  wire  miso = miso_oe_n ? ~miso_o : miso_o;
  modport dev  (input sclk, input cs_n, input mosi, output miso_o, output miso_oe_n);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// [hw/ssw_dev.sv]
// Device end: serial switch control port, 24-bit frames, fault readout.
// Assumes link pins are asynchronous to clk_sys_i and sclk runs under 6 MHz.
// Contract
// - Sample data in on sclk fall
// - Shift status out on sclk rise
// - Latch frame to outputs on select rise
// - Load fault status on select fall
// - Drive data out only while selected
// - Ignore clock and data while deselected
// - Host keeps sclk low at select edges
// - Host should park sclk low when idle
// - Fault reads one, normal reads zero
// - Command bit zero off, one on
// - Chain passes data; 24 bits per device (code passes the previous frame's bits, after status and a zero bit)
// - Parallel mode uses one select each
// - Fault bit set after filtered persistence
// - Host spaces accesses over 450 us
// - Host sclk no faster than 6 MHz
// - Full after 24 bits; act at rise
// - Status order: any, ov, zeros, outputs
// - Both frames most significant bit first
// - Code in bits 23:18, settings 15:0
`timescale 1ns/10ps
module ssw_dev
  import ssw_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   rstn_i,
  ssw_if.dev                          link,
  input  wire logic [SSW_NUM_OUT-1:0] fault_raw_i,
  input  wire logic                   ov_raw_i,
  output logic      [SSW_NUM_OUT-1:0] out_on_o,
  output logic                        frame_done_o,
  output logic                        frame_bad_o
);
  // Two-flop synchronisers, with a third stage on select and clock for edge detection
  logic [2:0] cs_s_r;
  logic [2:0] sck_s_r;
  logic [1:0] mosi_s_r;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_s_r   <= 3'h7;
      sck_s_r  <= 3'h0;
      mosi_s_r <= 2'h0;
    end else begin
      cs_s_r   <= {cs_s_r[1:0], link.cs_n};
      sck_s_r  <= {sck_s_r[1:0], link.sclk};
      mosi_s_r <= {mosi_s_r[0], link.mosi};
    end
  end

  // Edge decode from settled stages only
  wire sel      = ~cs_s_r[1];
  wire cs_fall  = cs_s_r[2] & ~cs_s_r[1];
  wire cs_rise  = ~cs_s_r[2] & cs_s_r[1];
  wire sck_rise = sel & ~sck_s_r[2] & sck_s_r[1];
  wire sck_fall = sel & sck_s_r[2] & ~sck_s_r[1];

  // Fault filters: one small counter per output plus overvoltage
  logic [SSW_NUM_OUT:0] flt_q;
  genvar g;
  generate
    for (g = 0; g <= SSW_NUM_OUT; g++) begin : g_flt
      logic [SSW_FLT_W-1:0] cnt_r;
      logic [1:0]           raw_s_r;
      wire                  raw_pin;
      // Overvoltage sits on the top slot; the per-output index never reaches it
      if (g == SSW_NUM_OUT) begin : g_ov
        assign raw_pin = ov_raw_i;
      end else begin : g_out
        assign raw_pin = fault_raw_i[g];
      end
      wire raw = raw_s_r[1];
      wire sat = (cnt_r == SSW_FLT_W'(SSW_FLT_CYC));
      // Raw fault levels come from the analog side, so synchronise before filtering
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          raw_s_r <= 2'h0;
          cnt_r   <= '0;
        end else begin
          raw_s_r <= {raw_s_r[0], raw_pin};
          if (!raw) cnt_r <= '0;
          else if (!sat) cnt_r <= cnt_r + 1'b1;
        end
      end
      assign flt_q[g] = sat;
    end
  endgenerate

  // Status frame image
  wire                      ov_flt  = flt_q[SSW_NUM_OUT];
  wire                      any_flt = |flt_q;
  wire [SSW_FRAME_BITS-1:0] status  = {any_flt, ov_flt, 6'h00, flt_q[SSW_NUM_OUT-1:0]};

  // Receive and transmit shift registers
  logic [SSW_FRAME_BITS-1:0] rx_r;
  logic [SSW_FRAME_BITS-1:0] tx_r;
  logic [SSW_CNT_W-1:0]      cnt_r;
  logic                      so_r;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_r  <= '0;
      cnt_r <= '0;
    end else if (cs_fall) begin
      cnt_r <= '0;
    end else if (sck_fall) begin
      rx_r  <= {rx_r[SSW_FRAME_BITS-2:0], mosi_s_r[1]};
      if (cnt_r != SSW_CNT_FULL) cnt_r <= cnt_r + 1'b1;
    end
  end

  // Transmit: MSB sits on the pin after load; each rise moves the next bit out
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_r <= '0;
      so_r <= 1'b0;
    end else if (cs_fall) begin
      tx_r <= {status[SSW_FRAME_BITS-2:0], 1'b0};
      so_r <= status[SSW_FRAME_BITS-1];
    end else if (sck_rise) begin
      so_r <= tx_r[SSW_FRAME_BITS-1];
      tx_r <= {tx_r[SSW_FRAME_BITS-2:0], rx_r[SSW_FRAME_BITS-1]};
    end
  end

  // Chain pass-through: after the status and one zero bit (25 clocks) the previous frame's received bits follow; this frame's bits follow after 49
  assign link.miso_o    = so_r;
  assign link.miso_oe_n = ~sel;

  // Apply command on select rise; partial frames are dropped
  wire                 full   = (cnt_r == SSW_CNT_FULL);
  wire [SSW_CMD_W-1:0] code   = rx_r[SSW_CMD_HI:SSW_CMD_LO];
  wire                 is_set = cs_rise & full & (code == SSW_CMD_ONOFF);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_on_o     <= SSW_OUT_RST;
      frame_done_o <= 1'b0;
      frame_bad_o  <= 1'b0;
    end else begin
      if (is_set) out_on_o <= rx_r[SSW_NUM_OUT-1:0];
      frame_done_o <= cs_rise & full;
      frame_bad_o  <= cs_rise & ~full;
    end
  end
endmodule // ssw_dev

// [hw/ssw_host.sv]
// Host end: serial bus master sending one 24-bit frame per request.
// Assumes one device, or a chain handled by repeated requests by the user.
`timescale 1ns/10ps
module ssw_host
  import ssw_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rstn_i,
  ssw_if.host                            link,
  input  wire logic                      req_i,
  input  wire logic [SSW_FRAME_BITS-1:0] cmd_i,
  output logic                           ready_o,
  output logic                           done_o,
  output logic      [SSW_FRAME_BITS-1:0] status_o
);
  typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_HIGH, HS_LOW, HS_LAG, HS_GAP} ssw_hs_t;
  ssw_hs_t                   st_r;
  logic [SSW_FRAME_BITS-1:0] sh_r;
  logic [SSW_FRAME_BITS-1:0] rx_r;
  logic [SSW_CNT_W-1:0]      bit_r;
  logic [SSW_DIV_W-1:0]      div_r;
  logic [SSW_GAP_W-1:0]      gap_r;
  logic                      sck_r;
  logic                      cs_n_r;
  logic [1:0]                miso_s_r;

  // Data-in comes from another domain's pin
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) miso_s_r <= 2'h0;
    else miso_s_r <= {miso_s_r[0], link.miso};
  end

  wire tick     = (div_r == SSW_DIV_W'(SSW_HALF_CYC - 1));
  wire last_bit = (bit_r == SSW_CNT_W'(SSW_FRAME_BITS - 1));
  wire gap_end  = (gap_r == SSW_GAP_W'(SSW_GAP_CYC));

  assign link.sclk = sck_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = sh_r[SSW_FRAME_BITS-1];
  assign ready_o   = (st_r == HS_IDLE);

  // Frame sequencer; sclk is always low when select moves
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= HS_IDLE; sh_r <= '0; rx_r <= '0; bit_r <= '0; div_r <= '0;
      gap_r <= '0; sck_r <= 1'b0; cs_n_r <= 1'b1; done_o <= 1'b0; status_o <= '0;
    end else begin
      done_o <= 1'b0;
      div_r  <= tick ? '0 : div_r + 1'b1;
      case (st_r)
        HS_IDLE: if (req_i) begin
          sh_r <= cmd_i; cs_n_r <= 1'b0; div_r <= '0; bit_r <= '0;
          st_r <= HS_LEAD;
        end
        HS_LEAD: if (tick) begin
          sck_r <= 1'b1; st_r <= HS_HIGH;
        end
        HS_HIGH: if (tick) begin
          sck_r <= 1'b0; // Device samples on this fall
          rx_r  <= {rx_r[SSW_FRAME_BITS-2:0], miso_s_r[1]};
          st_r  <= HS_LOW;
        end
        HS_LOW: if (tick) begin
          if (last_bit) st_r <= HS_LAG;
          else begin
            sh_r <= {sh_r[SSW_FRAME_BITS-2:0], 1'b0};
            bit_r <= bit_r + 1'b1; sck_r <= 1'b1; st_r <= HS_HIGH;
          end
        end
        HS_LAG: if (tick) begin
          cs_n_r <= 1'b1; status_o <= rx_r; done_o <= 1'b1;
          gap_r <= '0; st_r <= HS_GAP;
        end
        HS_GAP: begin
          gap_r <= gap_r + 1'b1;
          if (gap_end) st_r <= HS_IDLE;
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end
endmodule // ssw_host

// [tb/ssw_link_properties.sv]
// Checker: timing and framing rules on the serial link between host and switch port.
// Assumes it is instantiated beside the link interface, clocked by clk_sys_i.
`timescale 1ns/10ps
module ssw_link_properties
  import ssw_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic miso_oe_n
);
  logic                 sclk_r;
  logic [SSW_CNT_W-1:0] fall_r;
  logic [SSW_CNT_W-1:0] rise_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Edge counts per frame, cleared while deselected so each frame starts fresh
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_r <= 1'b0;
      fall_r <= '0;
      rise_r <= '0;
    end else begin
      sclk_r <= sclk;
      fall_r <= cs_n ? '0 : fall_r + SSW_CNT_W'(sclk_r & ~sclk);
      rise_r <= cs_n ? '0 : rise_r + SSW_CNT_W'(~sclk_r & sclk);
    end
  end
  // High half of the link clock, four system cycles
  sequence s_high_half;
    sclk [*4];
  endsequence
  a_oe_idle: assert property (cs_n [*4] |-> miso_oe_n)
    else $error("data out driven while deselected");
  a_oe_sel: assert property (!cs_n [*4] |-> !miso_oe_n)
    else $error("data out not driven while selected");
  a_sclk_at_cs: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
    else $error("link clock high at a select edge");
  a_sclk_parked: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock runs while deselected");
  a_fall_count: assert property ($rose(cs_n) |-> fall_r == SSW_CNT_FULL)
    else $error("wrong count of falling clock edges in frame");
  a_rise_count: assert property ($rose(cs_n) |-> rise_r == SSW_CNT_FULL)
    else $error("wrong count of rising clock edges in frame");
  a_mosi_held: assert property ($fell(sclk) |-> $stable(mosi))
    else $error("data in moved at the sampling edge");
  a_sclk_rate: assert property ($rose(sclk) |-> s_high_half)
    else $error("link clock high half too short");
endmodule // ssw_link_properties

// [tb/serial_switch_control_port_bench.sv]
// Bench: host and switch port joined back to back, self-checked through queues.
// Assumes nothing but the two ends drives the link.
`timescale 1ns/10ps
module serial_switch_control_port_bench;
  import ssw_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        req_i     = 1'b0;
  logic [23:0] cmd_i     = 24'h000000;
  logic [15:0] flt_r     = 16'h0000;
  logic        ov_r      = 1'b0;
  logic [23:0] status_o;
  logic [15:0] out_on_o;
  logic [15:0] on_exp;
  logic        ready_o;
  logic        done_o;
  logic        frame_done_o;
  logic        frame_bad_o;
  int          done_cnt   = 0;
  int          bad_cnt    = 0;
  logic [23:0] sq[$];
  logic [15:0] oq[$];
  int          mismatches = 0;
  int          compares   = 0;
  int          cyc        = 0;
  ssw_if lnk();
  ssw_host i_ssw_host (.clk_sys_i, .rstn_i, .link(lnk), .req_i, .cmd_i, .ready_o, .done_o,
                       .status_o);
  ssw_dev i_ssw_dev (.clk_sys_i, .rstn_i, .link(lnk), .fault_raw_i(flt_r), .ov_raw_i(ov_r),
                     .out_on_o, .frame_done_o, .frame_bad_o);
  ssw_link_properties i_ssw_link_properties (.clk_sys_i, .rstn_i, .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso_oe_n(lnk.miso_oe_n));
  always #20 clk_sys_i = ~clk_sys_i;
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp_stat(logic [23:0] e, logic [23:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] status_o expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_out(logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] out_on_o expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_cnt(string n, int e, int g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  // Frame pulses from the port, tallied for the closing count check
  always @(posedge clk_sys_i) begin
    if (frame_done_o === 1'b1) done_cnt++;
    if (frame_bad_o === 1'b1) bad_cnt++;
  end
  // Hang guard: six frames with the five gaps between them need about 58000 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Watcher: outputs settle 3 cycles after select rises, so look 6 cycles on
  always @(posedge clk_sys_i) begin
    if (done_o === 1'b1) begin
      cmp_stat(sq.pop_front(), status_o);
      repeat (6) @(posedge clk_sys_i);
      cmp_out(oq.pop_front(), out_on_o);
    end
  end
  // One frame; the fault change right after it is too young to show this time
  task automatic send(logic [23:0] c);
    do @(negedge clk_sys_i); while (ready_o !== 1'b1);
    sq.push_back({|flt_r | ov_r, ov_r, 6'h00, flt_r});
    if (c[23:18] == SSW_CMD_ONOFF) on_exp = c[15:0];
    oq.push_back(on_exp);
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    cmd_i <= c;
    flt_r <= flt_r | 16'($urandom() & $urandom());
    ov_r  <= ov_r | ($urandom() % 3 == 0);
    @(posedge clk_sys_i);
    req_i <= 1'b0;
  endtask
  // Main sequence: on/off codes alternate with codes that must be ignored
  initial begin
    on_exp = SSW_OUT_RST;
    void'($urandom(48517));
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      send({(i % 2) ? 6'($urandom_range(1, 63)) : SSW_CMD_ONOFF, 2'($urandom()),
            (i == 0) ? 16'hffff : (i == 4) ? 16'h0000 : 16'($urandom())});
    end
    repeat (400) @(posedge clk_sys_i);
    if (sq.size() != 0) mismatches++;
    cmp_cnt("frame_done_o", 6, done_cnt);
    cmp_cnt("frame_bad_o", 0, bad_cnt);
    end_of_test();
  end
endmodule // serial_switch_control_port_bench
